// [rtl/ssp_cfg.svh]
// Overview of operation
// - Eight-bit shift register, MSB first
// - Register and counter advance on clock falls
// - After eight pulses counter freezes shifting
// - Interrupt on eighth fall unless data written
// - Transfer interrupt disarmed after reset
// - Data register write arms the interrupt
// - Any disarm register write disarms interrupt
// - Interrupt line signals by falling transition
// - Reset or data write clears counter
// - Master mode: software toggles clock pin
// - Serial in input, serial out open-drain
// - Open-drain mode routes shift output out
// - Software may hold data low, stretch clock
// - Data line edge flags start condition
// - Unused port: no data writes, no interrupts
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_ADDR_W        8
`define SSP_DATA_W        8
`define SSP_OFS_DISARM    8'hc2
`define SSP_OFS_DATA      8'hdd
`define SSP_OFS_CTRL      8'he0
`define SSP_OFS_STATUS    8'he1
`define SSP_OFS_MASK      8'he2
`define SSP_CNT_W         4
`define SSP_CNT_LAST      4'h7
`define SSP_CNT_DONE_BIT  3
`define SSP_RST_DATA      8'h00
`define SSP_RST_CTRL      4'h0
`define SSP_RST_MASK      2'h0
`define SSP_EVT_W         2
`define SSP_EVT_DONE      0
`define SSP_EVT_START     1
`define SSP_STAT_CDO_BIT  4
`define SSP_STAT_ARM_BIT  5
`endif

// [rtl/ssp_pkg.sv]
package ssp_pkg;
  typedef struct packed {
    logic sin_hold_low;  // bit 3: pull serial input line low (acknowledge)
    logic sout_od;       // bit 2: serial output pin in open-drain serial mode
    logic scl_level;     // bit 1: level driven on clock pin in master mode
    logic scl_master;    // bit 0: clock pin is an output
  } ssp_ctrl_type;

  typedef struct packed {
    logic scl;
    logic sin;
  } ssp_pins_in_type;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sin_out;
    logic sin_oe;
    logic sout_out;
    logic sout_oe;
  } ssp_pins_out_type;
endpackage

// [rtl/ssp_serial_port.sv]
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_serial_port (
  input  wire logic                    sys_clk,    // 20 MHz system clock
  input  wire logic                    sys_rst,    // Synchronous reset, active high
  input  wire logic [`SSP_ADDR_W-1:0]  reg_addr,   // Register address
  input  wire logic [`SSP_DATA_W-1:0]  reg_wdata,  // Write data
  input  wire logic                    reg_wr,     // Write strobe
  input  wire logic                    reg_rd,     // Read strobe
  output logic      [`SSP_DATA_W-1:0]  reg_rdata,  // Read data, cycle after strobe
  input  wire ssp_pkg::ssp_pins_in_type pins_in,   // Clock and data pin levels
  output ssp_pkg::ssp_pins_out_type    pins_out,   // Pin drives and enables
  output logic                         done_irq_n, // Falls on completed armed transfer
  output logic                         irq         // Level, high on unmasked status
);
  import ssp_pkg::*;

  logic [1:0]                scl_sync;
  logic [1:0]                sin_sync;
  logic                      scl_prev;
  logic                      sin_prev;
  logic                      scl_fall;
  logic                      sin_fall;
  logic [`SSP_DATA_W-1:0]    shift_data;
  logic [`SSP_CNT_W-1:0]     bit_count;
  logic                      count_done_output;
  logic                      armed;
  ssp_ctrl_type              ctrl;
  logic [`SSP_EVT_W-1:0]     status;
  logic [`SSP_EVT_W-1:0]     mask;
  logic [`SSP_EVT_W-1:0]     events;
  logic                      wr_data;
  logic                      wr_disarm;
  logic                      rd_status;
  logic                      done_event;
  logic [`SSP_DATA_W-1:0]    next_rdata;

  function automatic logic hit(input logic [`SSP_ADDR_W-1:0] a,
                               input logic [`SSP_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_data   = reg_wr && hit(reg_addr, `SSP_OFS_DATA);
  assign wr_disarm = reg_wr && hit(reg_addr, `SSP_OFS_DISARM);
  assign rd_status = reg_rd && hit(reg_addr, `SSP_OFS_STATUS);

  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sin_sync <= 2'h3;
      scl_prev <= 1'b1;
      sin_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], pins_in.scl};
      sin_sync <= {sin_sync[0], pins_in.sin};
      scl_prev <= scl_sync[1];
      sin_prev <= sin_sync[1];
    end
  end

  // In master mode the clock pin is read back, so a stretched clock is seen too
  assign scl_fall = scl_prev && !scl_sync[1];
  assign sin_fall = sin_prev && !sin_sync[1];

  // Low once eight pulses are counted, which gates further shifting
  assign count_done_output = !bit_count[`SSP_CNT_DONE_BIT];

  assign done_event = scl_fall && count_done_output && armed
                      && (bit_count == `SSP_CNT_LAST) && !wr_data && !wr_disarm;

  // Shift register and counter; a processor write wins over a clock edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_data <= `SSP_RST_DATA;
      bit_count  <= '0;
    end else if (wr_data) begin
      shift_data <= reg_wdata;
      bit_count  <= '0;
    end else if (scl_fall && count_done_output) begin
      shift_data <= {shift_data[`SSP_DATA_W-2:0], sin_sync[1]};
      bit_count  <= bit_count + 4'h1;
    end
  end

  // Arming; stays clear while software never writes the data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else if (wr_data) begin
      armed <= 1'b1;
    end else if (wr_disarm) begin
      armed <= 1'b0;
    end
  end

  // Falling-edge request, held low until rearmed or disarmed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_irq_n <= 1'b1;
    end else if (done_event) begin
      done_irq_n <= 1'b0;
    end else if (wr_data || wr_disarm) begin
      done_irq_n <= 1'b1;
    end
  end

  assign events = {sin_fall, done_event};

  // Sticky status; a new event beats the read that clears it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= '0;
    end else if (rd_status) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl <= `SSP_RST_CTRL;
      mask <= `SSP_RST_MASK;
    end else if (reg_wr && hit(reg_addr, `SSP_OFS_CTRL)) begin
      ctrl <= reg_wdata[3:0];
    end else if (reg_wr && hit(reg_addr, `SSP_OFS_MASK)) begin
      mask <= reg_wdata[`SSP_EVT_W-1:0];
    end
  end

  // Open-drain output only ever pulls low, so out stays zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pins_out <= '0;
    end else begin
      pins_out.scl_oe   <= ctrl.scl_master;
      pins_out.scl_out  <= ctrl.scl_level;
      pins_out.sin_oe   <= ctrl.sin_hold_low;
      pins_out.sin_out  <= 1'b0;
      pins_out.sout_out <= 1'b0;
      pins_out.sout_oe  <= ctrl.sout_od && !shift_data[`SSP_DATA_W-1];
    end
  end

  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `SSP_OFS_DATA:   next_rdata = shift_data;
        `SSP_OFS_DISARM: next_rdata = '0;
        `SSP_OFS_CTRL:   next_rdata = {4'h0, ctrl};
        `SSP_OFS_MASK:   next_rdata = {6'h00, mask};
        `SSP_OFS_STATUS: next_rdata = {2'h0, armed, count_done_output, 2'h0, status};
        default:         next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// [testbench/ssp_serial_port_properties.sv]
`timescale 1ns/10ps
module ssp_serial_port_properties (
  input wire logic                      sys_clk,    // Clock
  input wire logic                      sys_rst,    // Reset
  input wire logic [7:0]                reg_addr,   // Address
  input wire logic [7:0]                reg_wdata,  // Data in
  input wire logic                      reg_wr,     // Write
  input wire logic                      reg_rd,     // Read
  input wire logic [7:0]                reg_rdata,  // Data out
  input wire ssp_pkg::ssp_pins_in_type  pins_in,    // Pins
  input wire ssp_pkg::ssp_pins_out_type pins_out,   // Drives
  input wire logic                      done_irq_n, // Done line
  input wire logic                      irq         // Interrupt
);
  import ssp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic       wr_off = reg_wr && reg_addr inside {8'hdd, 8'hc2};
  wire logic [2:0] ctl = {reg_wdata[3], reg_wdata[1:0]};
  sequence s_data_wr; reg_wr && reg_addr == 8'hdd; endsequence
  sequence s_ctrl_wr; reg_wr && reg_addr == 8'he0; endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_rd_disarm: assert property ($past(reg_rd) && $past(reg_addr) == 8'hc2 |-> !reg_rdata)
    else $error("disarm read not zero");
  a_done_release: assert property (wr_off |=> done_irq_n)
    else $error("done line not released");
  a_done_hold: assert property (!done_irq_n && !wr_off |=> !done_irq_n)
    else $error("done line let go");
  a_done_quiet: assert property (s_data_wr |=> done_irq_n [*8])
    else $error("done too soon");
  a_done_scl: assert property ($fell(done_irq_n) |-> $past(pins_in.scl, 3) == 1'b0)
    else $error("done without clock fall");
  a_od_low: assert property (!pins_out.sout_out && !pins_out.sin_out)
    else $error("open drain drives high");
  a_ctrl_pins: assert property (s_ctrl_wr |-> ##2
    {pins_out.sin_oe, pins_out.scl_out, pins_out.scl_oe} == $past(ctl, 2))
    else $error("pin drive mismatch");
endmodule
bind ssp_serial_port ssp_serial_port_properties ssp_serial_port_properties_i (.sys_clk,
  .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pins_in, .pins_out,
  .done_irq_n, .irq);

// [testbench/ssp_ext_master.sv]
`timescale 1ns/10ps
module ssp_ext_master (
  output logic scl,  // Clock drive
  output logic sin   // Data drive
);
  initial {scl, sin} = 2'b11;
  // Clock idles high between frames; data moves only while it is high
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sin = b[i];
      #200 scl = 1'b0;
      #200 scl = 1'b1;
    end
    #100 sin = ~sin;  // Data line flips from the last bit, so no stale bit shows
  endtask
endmodule

// [testbench/ssp_serial_port_tb_top.sv]
`timescale 1ns/10ps
module ssp_serial_port_tb_top;
  import ssp_pkg::*;
  logic             sys_clk, sys_rst, reg_wr, reg_rd, done_irq_n, irq, ext_scl, ext_sin;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, d;
  ssp_pins_in_type  pins_in;
  ssp_pins_out_type pins_out;
  int               error_cnt, n_tests, cyc;
  // Device drive wins on the clock; open drain pulls data low
  assign pins_in = {pins_out.scl_oe ? pins_out.scl_out : ext_scl, ext_sin & ~pins_out.sin_oe};
  ssp_serial_port ssp_serial_port_i (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pins_in, .pins_out, .done_irq_n, .irq);
  ssp_ext_master ssp_ext_master_i (.scl(ext_scl), .sin(ext_sin));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic rx(input logic [7:0] b);
    ssp_ext_master_i.send(b);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic t_unarmed();
    rd(8'hc2);
    chk(d, 8'h00);
    rx(8'h5a);
    chk({6'h0, irq, done_irq_n}, 8'h01);
    rd(8'hdd);
    chk(d, 8'h5a);
  endtask
  task automatic t_armed();
    wr(8'he2, 8'h01);
    wr(8'hdd, 8'h3c);
    rx(8'ha5);
    chk({6'h0, irq, done_irq_n}, 8'h02);
    rx(8'hff);
    rd(8'hdd);
    chk(d, 8'ha5);
    rd(8'he1);
    chk(d, 8'h23);
    wr(8'hc2, 8'h77);
    chk({6'h0, irq, done_irq_n}, 8'h01);
  endtask
  // Rewrite clears a frozen count, disarm keeps the next byte silent
  task automatic t_rewrite();
    wr(8'hdd, 8'h00);
    wr(8'hc2, 8'h00);
    rx(8'hc3);
    rd(8'hdd);
    chk(d, 8'hc3);
    chk({7'h0, done_irq_n}, 8'h01);
    wr(8'he0, 8'h0b);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({2'h0, pins_out}, 8'h34);
    wr(8'he0, 8'h04);
    wr(8'hdd, 8'h40);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({2'h0, pins_out}, 8'h01);
    wr(8'hc2, 8'h00);
    wr(8'he0, 8'h00);
  endtask
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0};
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_unarmed();
    t_armed();
    t_rewrite();
    finish_test();
  end
endmodule
